// ==== hw/spi_register_stream_crc.sv ====
// Target-side SPI register access sequencer with streaming, looping and CRC-8.
// Assumes SPI mode 0 on i_sclk; chip select low frames a transaction;
// configuration ports on i_mclk stay still while chip select is low.
`timescale 1ns/10ps
`include "spi_stream_defs.svh"
module spi_register_stream_crc (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_sclk,
    input wire logic i_csn,
    input wire logic i_sdi,
    output logic o_sdo,
    input wire logic i_single_instr,
    input wire logic i_addr_asc,
    input wire logic i_loop_keep,
    input wire logic i_loop_len_wr,
    input wire logic [7:0] i_loop_len,
    input wire logic i_crc_cfg_wr,
    input wire logic [1:0] i_crc_en,
    input wire logic [1:0] i_crc_en_b,
    input wire logic [6:0] i_user_addr,
    output logic [7:0] o_user_data,
    output logic o_crc_fail,
    output logic [1:0] o_crc_en,
    output logic [7:0] o_loop_len
);
    spi_stream_pkg::link_t lk_q;
    spi_stream_pkg::link_t lk_d;
    spi_stream_pkg::evt_t ev_q;
    spi_stream_pkg::evt_t ev_d;
    spi_stream_pkg::ctrl_t ct_q;
    spi_stream_pkg::ctrl_t ct_d;
    logic we0;
    logic we1;
    logic [6:0] wa0;
    logic [6:0] wa1;
    logic [7:0] wd0;
    logic [7:0] wd1;
    logic [6:0] raddr;
    logic [7:0] rdata;
    logic sdo_q;
    spi_stream_pkg::cfg_t cfg;
    assign cfg = ct_q.snap;

    function automatic logic [7:0] crc_bit(input logic [7:0] c, input logic b);
        crc_bit = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `CRC_POLY : 8'h00);
    endfunction : crc_bit

    function automatic logic is_multi(input logic [6:0] a);
        is_multi = (a >= `DESC_ONLY_ADDR) && (a != `ADDR_TOP);
    endfunction : is_multi

    function automatic logic [1:0] reg_size(input logic [6:0] a);
        reg_size = is_multi(a) ? 2'd2 : 2'd1;
    endfunction : reg_size

    function automatic logic in_map(input logic [6:0] a);
        in_map = a <= `ADDR_TOP;
    endfunction : in_map

    function automatic logic bit_at(input logic [7:0] v, input logic [2:0] n);
        bit_at = v[3'd7 - n];
    endfunction : bit_at

    function automatic logic [6:0] step(input logic [6:0] a, input logic asc);
        if (asc) begin
            step = (a == `ADDR_TOP) ? `ADDR_BOTTOM : a + 7'd1;
        end else begin
            step = (a == `ADDR_BOTTOM) ? `ADDR_TOP : a - 7'd1;
        end
    endfunction : step

    spi_reg_mem u_mem (
        .i_wclk(i_sclk),
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_we0(we0),
        .i_wa0(wa0),
        .i_wd0(wd0),
        .i_we1(we1),
        .i_wa1(wa1),
        .i_wd1(wd1),
        .i_ra(raddr),
        .o_rd(rdata),
        .i_ma(i_user_addr),
        .o_md(o_user_data)
    );

    // Link side: rising edge sampling, frame state cleared while chip select is high
    always_comb begin
        logic [7:0] byte_in;
        logic out_bit;
        logic commit;
        logic done;
        logic [6:0] nxt;
        byte_in = {lk_q.sh, i_sdi};
        out_bit = 1'b0;
        commit = 1'b0;
        done = 1'b0;
        nxt = lk_q.addr;
        lk_d = lk_q;
        ev_d = ev_q;
        raddr = lk_q.addr;
        we0 = 1'b0;
        we1 = 1'b0;
        wa0 = lk_q.a0;
        wa1 = lk_q.a1;
        wd0 = lk_q.d0;
        wd1 = lk_q.d1;
        lk_d.started = 1'b1;
        if (!lk_q.started) begin
            ev_d.pend = 1'b0;
        end
        lk_d.sh = byte_in[6:0];
        lk_d.bit_cnt = lk_q.bit_cnt + 3'd1;
        unique case (lk_q.phase)
            spi_stream_pkg::PH_INSTR: begin
                lk_d.crc = crc_bit(lk_q.crc, i_sdi);
                if (lk_q.bit_cnt == 3'd7) begin
                    lk_d.rd = lk_q.sh[6];
                    lk_d.addr = byte_in[6:0];
                    lk_d.start = byte_in[6:0];
                    lk_d.loop_cnt = 8'h00;
                    lk_d.reg_rem = reg_size(byte_in[6:0]);
                    lk_d.buf_n = 2'd0;
                    lk_d.phase = spi_stream_pkg::PH_DATA;
                    raddr = byte_in[6:0];
                end
            end
            spi_stream_pkg::PH_DATA: begin
                out_bit = bit_at(rdata, lk_q.bit_cnt);
                lk_d.crc = crc_bit(lk_q.crc, lk_q.rd ? out_bit : i_sdi);
                if (lk_q.bit_cnt == 3'd7) begin
                    if (lk_q.buf_n == 2'd0) begin
                        lk_d.a0 = lk_q.addr;
                        lk_d.d0 = byte_in;
                    end else begin
                        lk_d.a1 = lk_q.addr;
                        lk_d.d1 = byte_in;
                    end
                    lk_d.buf_n = lk_q.buf_n + 2'd1;
                    lk_d.reg_rem = lk_q.reg_rem - 2'd1;
                    nxt = step(lk_q.addr, cfg.asc);
                    lk_d.loop_cnt = lk_q.loop_cnt + 8'd1;
                    if (cfg.loop_len != 8'h00 && lk_d.loop_cnt == cfg.loop_len) begin
                        nxt = lk_q.start;
                        lk_d.loop_cnt = 8'h00;
                    end
                    lk_d.addr = nxt;
                    raddr = nxt;
                    if (lk_q.reg_rem == 2'd1) begin
                        if (cfg.crc_on) begin
                            lk_d.phase = spi_stream_pkg::PH_CRC;
                            lk_d.crc_hold = lk_d.crc;
                            ev_d.pend = !lk_q.rd;
                        end else begin
                            commit = !lk_q.rd;
                            done = 1'b1;
                            wa0 = lk_d.a0;
                            wa1 = lk_d.a1;
                            wd0 = lk_d.d0;
                            wd1 = lk_d.d1;
                        end
                    end
                end
            end
            spi_stream_pkg::PH_CRC: begin
                out_bit = bit_at(lk_q.crc_hold, lk_q.bit_cnt);
                if (lk_q.bit_cnt == 3'd7) begin
                    done = 1'b1;
                    ev_d.pend = 1'b0;
                    if (!lk_q.rd) begin
                        if (byte_in == lk_q.crc_hold) begin
                            commit = 1'b1;
                        end else begin
                            ev_d.fail_tgl = !ev_q.fail_tgl;
                        end
                    end
                end
            end
            default: begin
                lk_d.phase = spi_stream_pkg::PH_INSTR;
            end
        endcase
        if (commit) begin
            // Whole register or nothing; high multibyte region refuses ascending writes
            if (!(cfg.asc && is_multi(wa0))) begin
                we0 = in_map(wa0);
                we1 = (lk_d.buf_n == 2'd2) && in_map(wa1);
                if (wa0 == `FLAG_CLR_ADDR && wd0[`FLAG_CLR_BIT]) begin
                    ev_d.clr_tgl = !ev_q.clr_tgl;
                end
            end
        end
        if (done) begin
            lk_d.buf_n = 2'd0;
            lk_d.reg_rem = reg_size(lk_d.addr);
            if (cfg.single) begin
                lk_d.phase = spi_stream_pkg::PH_INSTR;
                lk_d.crc = `CRC_SEED;
            end else begin
                lk_d.phase = spi_stream_pkg::PH_DATA;
                lk_d.crc = {1'b0, lk_d.addr};
            end
        end
    end

    always_ff @(posedge i_sclk or posedge i_csn) begin
        if (i_csn) begin
            lk_q <= '{started: 1'b0,
                      phase: spi_stream_pkg::PH_INSTR,
                      rd: 1'b0,
                      bit_cnt: 3'd0,
                      sh: 7'h00,
                      addr: 7'h00,
                      start: 7'h00,
                      loop_cnt: 8'h00,
                      reg_rem: 2'd0,
                      crc: `CRC_SEED,
                      crc_hold: 8'h00,
                      buf_n: 2'd0,
                      a0: 7'h00,
                      a1: 7'h00,
                      d0: 8'h00,
                      d1: 8'h00};
        end else begin
            lk_q <= lk_d;
        end
    end

    always_ff @(posedge i_sclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ev_q <= '0;
        end else begin
            ev_q <= ev_d;
        end
    end

    // Output bit launched on the falling edge, half a period ahead of sampling
    always_ff @(negedge i_sclk or negedge i_rstn) begin
        if (!i_rstn) begin
            sdo_q <= 1'b0;
        end else if (lk_q.phase == spi_stream_pkg::PH_CRC) begin
            sdo_q <= bit_at(lk_q.crc_hold, lk_q.bit_cnt);
        end else if (lk_q.phase == spi_stream_pkg::PH_DATA && lk_q.rd) begin
            sdo_q <= bit_at(rdata, lk_q.bit_cnt);
        end else begin
            sdo_q <= 1'b0;
        end
    end

    // System side: configuration, loop length, failure flag
    always_comb begin
        logic cs_rise;
        cs_rise = ct_q.csn_s[1] && !ct_q.csn_s[2];
        ct_d = ct_q;
        ct_d.csn_s = {ct_q.csn_s[1:0], i_csn};
        ct_d.pend_s = {ct_q.pend_s[0], ev_q.pend};
        ct_d.fail_s = {ct_q.fail_s[1:0], ev_q.fail_tgl};
        ct_d.clr_s = {ct_q.clr_s[1:0], ev_q.clr_tgl};
        if (cs_rise && !i_loop_keep) begin
            ct_d.loop_len = `LOOP_RST;
        end
        if (i_loop_len_wr) begin
            ct_d.loop_len = i_loop_len;
        end
        if (i_crc_cfg_wr && (i_crc_en_b == ~i_crc_en)) begin
            ct_d.crc_en = i_crc_en;
        end
        if (ct_q.clr_s[2] != ct_q.clr_s[1]) begin
            ct_d.crc_fail = 1'b0;
        end
        if ((ct_q.fail_s[2] != ct_q.fail_s[1]) || (cs_rise && ct_q.pend_s[1])) begin
            ct_d.crc_fail = 1'b1;
        end
        if (ct_q.csn_s[1]) begin
            ct_d.snap.single = i_single_instr;
            ct_d.snap.asc = i_addr_asc;
            ct_d.snap.crc_on = ct_q.crc_en == `CRC_EN_ON;
            ct_d.snap.loop_len = ct_q.loop_len;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ct_q <= '{csn_s: 3'b111,
                      pend_s: 2'b00,
                      fail_s: 3'b000,
                      clr_s: 3'b000,
                      crc_fail: 1'b0,
                      crc_en: `CRC_EN_RST,
                      loop_len: `LOOP_RST,
                      snap: '{single: 1'b0,
                             asc: 1'b0,
                             crc_on: 1'b0,
                             loop_len: `LOOP_RST}};
        end else begin
            ct_q <= ct_d;
        end
    end

    assign o_sdo = sdo_q;
    assign o_crc_fail = ct_q.crc_fail;
    assign o_crc_en = ct_q.crc_en;
    assign o_loop_len = ct_q.loop_len;
endmodule : spi_register_stream_crc

// ==== hw/spi_stream_defs.svh ====
// Constants of the streaming SPI register sequencer.
// Assumes inclusion by bare name from the package and design files.
// Notes on behaviour
// - Single-access mode: new instruction after each register
// - Select bit 0 means streaming, default after reset
// - Streaming steps address by one after every byte
// - Descending without loop wraps 0x00 to 0x4b
// - Ascending wraps 0x4b to 0x00; high multibyte blocked
// - Nonzero loop length returns to start address
// - Chip select rise clears loop length unless retained
// - Check code is CRC-8, polynomial 0x07
// - Enable field changes only with inverted complement
// - Enable change applies from the next frame
// - Writes: device echoes its code, compares host's
// - Reads: device code covers seed, address, data
// - One check byte after whole multibyte register
// - Bad or missing check byte drops write, flags
// - Writing 1 clears flag; with check on, only with good code
// - Seed 0xa5, later streaming codes seed address
// - Direction bit 0 decrements, 1 increments
// - Instruction: read bit high, then 7-bit address
`ifndef SPI_STREAM_DEFS_SVH
`define SPI_STREAM_DEFS_SVH
`define ADDR_W 7
`define MEM_DEPTH 76
`define ADDR_TOP 7'h4b
`define ADDR_BOTTOM 7'h00
`define DESC_ONLY_ADDR 7'h29
`define CRC_SEED 8'ha5
`define CRC_POLY 8'h07
`define CRC_EN_ON 2'b01
`define CRC_EN_RST 2'b00
`define FLAG_CLR_ADDR 7'h11
`define FLAG_CLR_BIT 0
`define LOOP_RST 8'h00
`endif

// ==== hw/spi_stream_pkg.sv ====
// Types shared by the streaming SPI register sequencer.
// Assumes the constants header is compiled alongside.
`include "spi_stream_defs.svh"
package spi_stream_pkg;
    typedef enum logic [1:0] {
        PH_INSTR = 2'b00,
        PH_DATA = 2'b01,
        PH_CRC = 2'b10
    } phase_t;

    typedef struct packed {
        logic single;
        logic asc;
        logic crc_on;
        logic [7:0] loop_len;
    } cfg_t;

    typedef struct packed {
        logic started;
        phase_t phase;
        logic rd;
        logic [2:0] bit_cnt;
        logic [6:0] sh;
        logic [6:0] addr;
        logic [6:0] start;
        logic [7:0] loop_cnt;
        logic [1:0] reg_rem;
        logic [7:0] crc;
        logic [7:0] crc_hold;
        logic [1:0] buf_n;
        logic [6:0] a0;
        logic [6:0] a1;
        logic [7:0] d0;
        logic [7:0] d1;
    } link_t;

    typedef struct packed {
        logic pend;
        logic fail_tgl;
        logic clr_tgl;
    } evt_t;

    typedef struct packed {
        logic [2:0] csn_s;
        logic [1:0] pend_s;
        logic [2:0] fail_s;
        logic [2:0] clr_s;
        logic crc_fail;
        logic [1:0] crc_en;
        logic [7:0] loop_len;
        cfg_t snap;
    } ctrl_t;
endpackage : spi_stream_pkg

// ==== hw/spi_reg_mem.sv ====
// Byte register array: two write ports and a read port on the link clock,
// one registered read port on the system clock.
// Assumes write addresses stay below the depth.
`timescale 1ns/10ps
`include "spi_stream_defs.svh"
module spi_reg_mem (
    input wire logic i_wclk,
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_we0,
    input wire logic [6:0] i_wa0,
    input wire logic [7:0] i_wd0,
    input wire logic i_we1,
    input wire logic [6:0] i_wa1,
    input wire logic [7:0] i_wd1,
    input wire logic [6:0] i_ra,
    output logic [7:0] o_rd,
    input wire logic [6:0] i_ma,
    output logic [7:0] o_md
);
    logic [7:0] mem [0:`MEM_DEPTH-1];

    always_ff @(posedge i_wclk) begin
        if (i_we0) begin
            mem[i_wa0] <= i_wd0;
        end
        if (i_we1) begin
            mem[i_wa1] <= i_wd1;
        end
    end

    always_ff @(posedge i_wclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rd <= 8'h00;
        end else begin
            o_rd <= (i_ra < 7'(`MEM_DEPTH)) ? mem[i_ra] : 8'h00;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_md <= 8'h00;
        end else begin
            o_md <= (i_ma < 7'(`MEM_DEPTH)) ? mem[i_ma] : 8'h00;
        end
    end
endmodule : spi_reg_mem

// ==== dv/spi_stream_asserts.sv ====
// Checker of the mclk-side ports of the sequencer.
// Assumes the bind below; one clock domain.
`timescale 1ns/10ps
module spi_stream_asserts (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_csn,
    input wire logic i_loop_keep,
    input wire logic i_loop_len_wr,
    input wire logic [7:0] i_loop_len,
    input wire logic i_crc_cfg_wr,
    input wire logic [1:0] i_crc_en,
    input wire logic [1:0] i_crc_en_b,
    input wire logic o_crc_fail,
    input wire logic [1:0] o_crc_en,
    input wire logic [7:0] o_loop_len
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);
    property p_en_take;
        i_crc_cfg_wr && i_crc_en_b == ~i_crc_en |=> o_crc_en == $past(i_crc_en);
    endproperty
    a_en_take: assert property (p_en_take) else $error("enable not taken");
    property p_en_bad;
        i_crc_cfg_wr && i_crc_en_b != ~i_crc_en |=> $stable(o_crc_en);
    endproperty
    a_en_bad: assert property (p_en_bad) else $error("enable taken");
    property p_en_hold;
        !i_crc_cfg_wr |=> $stable(o_crc_en);
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable moved");
    property p_loop_wr;
        i_loop_len_wr |=> o_loop_len == $past(i_loop_len);
    endproperty
    a_loop_wr: assert property (p_loop_wr) else $error("loop not loaded");
    property p_loop_clr;
        $rose(i_csn) && !i_loop_keep |-> ##[1:8] o_loop_len == 8'h00;
    endproperty
    a_loop_clr: assert property (p_loop_clr) else $error("loop not cleared");
    property p_loop_keep;
        i_loop_keep && !i_loop_len_wr |=> $stable(o_loop_len);
    endproperty
    a_loop_keep: assert property (p_loop_keep) else $error("loop lost");
    property p_fail_set;
        $rose(o_crc_fail) |-> o_crc_en == 2'b01;
    endproperty
    a_fail_set: assert property (p_fail_set) else $error("flag without check");
    property p_fail_hold;
        (o_crc_fail && i_csn) [*6] |=> o_crc_fail;
    endproperty
    a_fail_hold: assert property (p_fail_hold) else $error("flag dropped");
endmodule : spi_stream_asserts
bind spi_register_stream_crc spi_stream_asserts u_chk (.i_mclk(i_mclk), .i_rstn(i_rstn),
    .i_csn(i_csn), .i_loop_keep(i_loop_keep), .i_loop_len_wr(i_loop_len_wr),
    .i_loop_len(i_loop_len), .i_crc_cfg_wr(i_crc_cfg_wr), .i_crc_en(i_crc_en),
    .i_crc_en_b(i_crc_en_b), .o_crc_fail(o_crc_fail), .o_crc_en(o_crc_en),
    .o_loop_len(o_loop_len));

// ==== dv/spi_host_model.sv ====
// Host model of the SPI link: single lane, mode 0.
// Assumes callers wait out each task; SCLK runs only inside frames.
`timescale 1ns/10ps
module spi_host_model (
    output logic o_sclk,
    output logic o_csn,
    output logic o_sdi,
    input wire logic i_sdo
);
    initial begin
        o_sclk = 1'b0;
        o_csn = 1'b1;
        o_sdi = 1'b0;
    end
    function automatic logic [7:0] crc8(input logic [7:0] s, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            s = {s[6:0], 1'b0} ^ ((s[7] ^ b[i]) ? 8'h07 : 8'h00);
        end
        return s;
    endfunction : crc8
    task automatic open_f();
        o_csn = 1'b0;
        #100;
    endtask : open_f
    task automatic xb(input logic [7:0] b, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            o_sdi = b[i];
            #32 o_sclk = 1'b1;
            r[i] = i_sdo;
            #32 o_sclk = 1'b0;
        end
    endtask : xb
    task automatic close_f();
        #64 o_csn = 1'b1;
        o_sdi = ~o_sdi;
        #200;
    endtask : close_f
endmodule : spi_host_model

// ==== dv/spi_register_stream_crc_tb_top.sv ====
// Self-checking bench of the streaming SPI register sequencer.
// Assumes the host model owns the link; mclk inputs move on rising edges.
`timescale 1ns/10ps
module spi_register_stream_crc_tb_top;
    logic i_mclk = 1'b0;
    logic i_rstn = 1'b0;
    logic single = 1'b0, asc = 1'b0, keep = 1'b0, lwr = 1'b0, cwr = 1'b0;
    logic [1:0] en = 2'b00, enb = 2'b00, en_q;
    logic [6:0] uaddr = 7'h00;
    logic [7:0] llen = 8'h00, udata, lcur, r, c, o;
    logic sclk, csn, sdi, sdo, fail;
    logic [7:0] d [4];
    int error_cnt = 0;
    int num_checks = 0;
    always #12.5 i_mclk = ~i_mclk;
    spi_host_model host (.o_sclk(sclk), .o_csn(csn), .o_sdi(sdi), .i_sdo(sdo));
    spi_register_stream_crc dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_sclk(sclk),
        .i_csn(csn), .i_sdi(sdi), .o_sdo(sdo), .i_single_instr(single), .i_addr_asc(asc),
        .i_loop_keep(keep), .i_loop_len_wr(lwr), .i_loop_len(llen), .i_crc_cfg_wr(cwr),
        .i_crc_en(en), .i_crc_en_b(enb), .i_user_addr(uaddr), .o_user_data(udata),
        .o_crc_fail(fail), .o_crc_en(en_q), .o_loop_len(lcur));
    task automatic final_report();
        $display("Checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : tick
    task automatic rnd();
        foreach (d[i]) d[i] = 8'($urandom());
    endtask : rnd
    task automatic peek(input logic [6:0] a, input logic [7:0] exp);
        tick(1);
        uaddr <= a;
        tick(2);
        cmp(udata, exp);
    endtask : peek
    task automatic mode(input logic s, input logic a, input logic k);
        tick(1);
        single <= s;
        asc <= a;
        keep <= k;
        tick(4);
    endtask : mode
    task automatic pulse(input logic crc, input logic [7:0] v, input logic [1:0] vb);
        tick(1);
        cwr <= crc;
        lwr <= !crc;
        llen <= v;
        en <= v[1:0];
        enb <= vb;
        tick(1);
        cwr <= 1'b0;
        lwr <= 1'b0;
        tick(4);
    endtask : pulse
    task automatic frame(input logic [7:0] ins, input int n, input bit crc, input logic [7:0] bad);
        logic [7:0] s;
        logic [7:0] h;
        s = host.crc8(8'ha5, ins);
        h = s;
        host.open_f();
        host.xb(ins, r);
        for (int i = 0; i < n; i++) begin
            host.xb(ins[7] ? 8'h00 : d[i], r);
            if (ins[7]) cmp(r, d[i]);
            s = host.crc8(s, d[i]);
            h = host.crc8(h, ins[7] ? 8'h00 : d[i]);
            if (crc) begin
                host.xb(h ^ bad, c);
                cmp(c, s);
                s = {1'b0, ins[6:0] - 7'(i + 1)};
                h = s;
            end
        end
        host.close_f();
    endtask : frame
    initial begin
        #400000;
        error_cnt++;
        final_report();
    end
    initial begin
        void'($urandom(32'hc38fe33b));
        tick(12);
        i_rstn <= 1'b1;
        tick(4);
        cmp({6'h00, en_q}, 8'h00);
        cmp(lcur, 8'h00);
        rnd();
        frame(8'h01, 3, 1'b0, 8'h00);
        peek(7'h00, d[1]);
        peek(7'h4b, d[2]);
        frame(8'h81, 3, 1'b0, 8'h00);
        rnd();
        frame(8'h2a, 2, 1'b0, 8'h00);
        peek(7'h2a, d[0]);
        o = d[1];
        mode(1'b0, 1'b1, 1'b0);
        frame(8'h4b, 2, 1'b0, 8'h00);
        peek(7'h00, d[1]);
        rnd();
        frame(8'h29, 2, 1'b0, 8'h00);
        peek(7'h29, o);
        mode(1'b0, 1'b0, 1'b0);
        frame(8'h04, 1, 1'b0, 8'h00);
        o = d[0];
        pulse(1'b0, 8'h02, 2'b00);
        rnd();
        frame(8'h06, 4, 1'b0, 8'h00);
        peek(7'h06, d[2]);
        peek(7'h05, d[3]);
        peek(7'h04, o);
        cmp(lcur, 8'h00);
        mode(1'b0, 1'b0, 1'b1);
        pulse(1'b0, 8'h03, 2'b00);
        frame(8'h07, 1, 1'b0, 8'h00);
        cmp(lcur, 8'h03);
        pulse(1'b0, 8'h00, 2'b00);
        mode(1'b1, 1'b0, 1'b0);
        host.open_f();
        host.xb(8'h07, r);
        host.xb(d[0], r);
        host.xb(8'h09, r);
        host.xb(d[1], r);
        host.close_f();
        peek(7'h07, d[0]);
        peek(7'h09, d[1]);
        host.open_f();
        host.xb(8'h87, r);
        host.xb(8'h00, r);
        cmp(r, d[0]);
        host.xb(8'h89, r);
        host.xb(8'h00, r);
        cmp(r, d[1]);
        host.close_f();
        mode(1'b0, 1'b0, 1'b0);
        pulse(1'b1, 8'h01, 2'b01);
        cmp({6'h00, en_q}, 8'h00);
        pulse(1'b1, 8'h01, 2'b10);
        cmp({6'h00, en_q}, 8'h01);
        frame(8'h0a, 1, 1'b1, 8'h00);
        o = d[0];
        peek(7'h0a, o);
        rnd();
        frame(8'h0a, 1, 1'b1, 8'h01);
        peek(7'h0a, o);
        cmp({7'h00, fail}, 8'h01);
        d[0] = o;
        frame(8'h8a, 1, 1'b1, 8'h00);
        rnd();
        frame(8'h0d, 2, 1'b1, 8'h00);
        peek(7'h0c, d[1]);
        d[0] = 8'h01;
        frame(8'h11, 1, 1'b1, 8'h80);
        cmp({7'h00, fail}, 8'h01);
        frame(8'h11, 1, 1'b1, 8'h00);
        cmp({7'h00, fail}, 8'h00);
        frame(8'h0b, 1, 1'b0, 8'h00);
        cmp({7'h00, fail}, 8'h01);
        pulse(1'b1, 8'h00, 2'b11);
        cmp({6'h00, en_q}, 8'h00);
        final_report();
    end
endmodule : spi_register_stream_crc_tb_top
